// ### hdl/ttc_pkg.sv
// constants, types and helpers shared by the tagged translation cache
package ttc_pkg;

    localparam int TTC_TAG_W = 12;
    localparam int TTC_LIN_W = 48;
    localparam int TTC_PHYS_W = 52;
    localparam int TTC_VPN_W = 36;
    localparam int TTC_PFN_W = 40;
    localparam int TTC_OFS_W = 12;
    localparam int TTC_MT_W = 3;
    localparam int TTC_ENTRIES = 8;
    localparam int TTC_IDX_W = 3;

    // control register bit positions
    localparam int TTC_TEF_BIT = 17;
    localparam int TTC_LPE_BIT = 4;
    localparam int TTC_EXT_BIT = 5;
    localparam int TTC_PG_BIT = 31;

    // control register write selects
    localparam logic [1:0] TTC_SEL_SYSC = 2'h0;
    localparam logic [1:0] TTC_SEL_BASE = 2'h2;
    localparam logic [1:0] TTC_SEL_FCR = 2'h3;

    // values after reset
    localparam logic [31:0] TTC_SYSC_RST = 32'h0000_0000;
    localparam logic [31:0] TTC_FCR_RST = 32'h0000_0000;
    localparam logic [63:0] TTC_BASE_RST = 64'h0000_0000_0000_0000;
    localparam logic [TTC_TAG_W-1:0] TTC_TAG_NONE = 12'h000;
    localparam logic [TTC_IDX_W-1:0] TTC_VICTIM_RST = 3'h0;
    localparam logic [TTC_MT_W-1:0] TTC_MT_UNPAGED = 3'h0;

    // page-number bits that fall into the offset, by page size
    localparam logic [TTC_VPN_W-1:0] TTC_MASK_4K = 36'h0_0000_0000;
    localparam logic [TTC_VPN_W-1:0] TTC_MASK_2M = 36'h0_0000_01ff;
    localparam logic [TTC_VPN_W-1:0] TTC_MASK_4M = 36'h0_0000_03ff;
    localparam logic [TTC_VPN_W-1:0] TTC_MASK_1G = 36'h0_0003_ffff;

    typedef enum logic [1:0] {
        TTC_MODE_OFF = 2'b00,
        TTC_MODE_P32 = 2'b01,
        TTC_MODE_EXT = 2'b10,
        TTC_MODE_FOUR = 2'b11
    } ttc_mode_type;

    typedef enum logic [1:0] {
        TTC_SZ_4K = 2'b00,
        TTC_SZ_2M = 2'b01,
        TTC_SZ_4M = 2'b10,
        TTC_SZ_1G = 2'b11
    } ttc_size_type;

    typedef struct packed {
        logic valid;
        logic [TTC_TAG_W-1:0] tag;
        logic global_page;
        ttc_size_type size;
        logic [TTC_VPN_W-1:0] vpn;
        logic [TTC_PFN_W-1:0] frame;
        logic rw;
        logic us;
        logic xd;
        logic dirty;
        logic [TTC_MT_W-1:0] mtype;
    } ttc_entry_type;

    function automatic logic [TTC_VPN_W-1:0] ttc_offset_mask(input ttc_size_type sz);
        unique case (sz)
            TTC_SZ_4K: return TTC_MASK_4K;
            TTC_SZ_2M: return TTC_MASK_2M;
            TTC_SZ_4M: return TTC_MASK_4M;
            TTC_SZ_1G: return TTC_MASK_1G;
        endcase
    endfunction

endpackage

// ### hdl/ttc_page_sizer.sv
// page size of a fresh walk result from paging mode and page-size bits
`timescale 1ns/100ps
module ttc_page_sizer (
    input wire ttc_pkg::ttc_mode_type mode,
    input wire logic large_page_enable,
    input wire logic dir_pointer_ps,
    input wire logic directory_ps,
    output ttc_pkg::ttc_size_type size
);
    import ttc_pkg::*;

    always_comb begin
        size = TTC_SZ_4K;
        unique case (mode)
            TTC_MODE_P32: begin
                if (large_page_enable && directory_ps) begin
                    size = TTC_SZ_4M;
                end
            end
            TTC_MODE_EXT: begin
                if (directory_ps) begin
                    size = TTC_SZ_2M;
                end
            end
            TTC_MODE_FOUR: begin
                if (dir_pointer_ps) begin
                    size = TTC_SZ_1G;
                end else if (directory_ps) begin
                    size = TTC_SZ_2M;
                end
            end
            TTC_MODE_OFF: size = TTC_SZ_4K;
        endcase
    end

endmodule

// ### hdl/ttc_entry_match.sv
// hit test of one cached translation against a lookup
`timescale 1ns/100ps
module ttc_entry_match (
    input wire ttc_pkg::ttc_entry_type entry,
    input wire logic [ttc_pkg::TTC_VPN_W-1:0] vpn,
    input wire logic [ttc_pkg::TTC_TAG_W-1:0] cur_tag,
    output logic hit
);
    import ttc_pkg::*;

    logic [TTC_VPN_W-1:0] ignore;
    logic vpn_eq;
    logic tag_ok;

    always_comb begin
        ignore = ttc_offset_mask(entry.size);
        vpn_eq = ((entry.vpn ^ vpn) & ~ignore) == '0;
        tag_ok = (entry.tag == cur_tag) || entry.global_page;
        hit = entry.valid && vpn_eq && tag_ok;
    end

endmodule

// ### hdl/ttc_cache.sv
// tagged translation cache: control registers, lookup and fill
//
// How it works
// - memory type served from cached entries
// - current tag is base bits, else zero
// - tag enable sits at bit 17
// - illegal tag enable rise faults, no change
// - paging off with tags enabled faults
// - tags only enabled in four-level paging
// - new entries stored with current tag
// - lookups match only current-tag or global entries
// - tags disabled means only tag zero cached
// - clearing tag enable flushes every entry
// - tag switch keeps other-tag entries cached
// - frame high bits, linear offset low bits
// - 32-bit: 4M or 4K page numbers
// - extended 32-bit: 2M or 4K pages
// - four-level: 1G, 2M or 4K pages
// - global entries hit under any tag
// - entry holds frame, rights, dirty, type
// - cache only valid, fully accessed walks
`timescale 1ns/100ps
module ttc_cache (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cr_wr_valid,
    input wire logic [1:0] cr_wr_sel,
    input wire logic [63:0] cr_wr_data,
    input wire logic long_mode_active,
    input wire logic inv_all,
    input wire logic lk_valid,
    input wire logic [ttc_pkg::TTC_LIN_W-1:0] lk_addr,
    input wire logic fill_valid,
    input wire logic [ttc_pkg::TTC_LIN_W-1:0] fill_addr,
    input wire logic [ttc_pkg::TTC_PFN_W-1:0] fill_frame,
    input wire logic fill_dir_pointer_ps,
    input wire logic fill_directory_ps,
    input wire logic fill_rw,
    input wire logic fill_us,
    input wire logic fill_xd,
    input wire logic fill_dirty,
    input wire logic fill_global,
    input wire logic [ttc_pkg::TTC_MT_W-1:0] fill_mtype,
    input wire logic fill_walk_ok,
    input wire logic fill_accessed_all,
    output logic [31:0] system_control_reg,
    output logic [31:0] fourth_control_reg,
    output logic [63:0] translation_base_reg,
    output logic [ttc_pkg::TTC_TAG_W-1:0] address_space_tag,
    output logic protection_fault,
    output logic lk_done,
    output logic lk_hit,
    output logic lk_walk_req,
    output logic [ttc_pkg::TTC_PHYS_W-1:0] lk_phys,
    output logic lk_rw,
    output logic lk_us,
    output logic lk_xd,
    output logic lk_dirty,
    output logic [ttc_pkg::TTC_MT_W-1:0] lk_mtype,
    output logic fill_done,
    output logic fill_accessed_req
);
    import ttc_pkg::*;

    typedef struct packed {
        ttc_entry_type [TTC_ENTRIES-1:0] ent;
        logic [TTC_IDX_W-1:0] victim;
        logic [31:0] sysc;
        logic [31:0] fcr;
        logic [63:0] base;
        logic [TTC_TAG_W-1:0] tag;
        logic fault;
        logic lk_done;
        logic lk_hit;
        logic lk_walk;
        logic [TTC_PHYS_W-1:0] lk_phys;
        logic lk_rw;
        logic lk_us;
        logic lk_xd;
        logic lk_dirty;
        logic [TTC_MT_W-1:0] lk_mtype;
        logic fill_done;
        logic fill_acc_req;
    } ttc_state_type;

    ttc_state_type q;
    ttc_state_type next_q;

    ttc_mode_type mode;
    ttc_size_type fill_size;
    logic [TTC_ENTRIES-1:0] hit_vec;
    ttc_entry_type sel;
    logic [TTC_PFN_W-1:0] keep_lin;
    logic [TTC_PFN_W-1:0] lin_pfn;
    logic flush;
    logic tef_old;
    logic tef_new;
    logic bad_rise;
    logic bad_pg_clear;
    logic tef_clear;
    logic fill_take;
    ttc_entry_type fresh;

    // active paging mode from the committed control registers
    always_comb begin
        if (!q.sysc[TTC_PG_BIT]) begin
            mode = TTC_MODE_OFF;
        end else if (long_mode_active) begin
            mode = TTC_MODE_FOUR;
        end else if (q.fcr[TTC_EXT_BIT]) begin
            mode = TTC_MODE_EXT;
        end else begin
            mode = TTC_MODE_P32;
        end
    end

    ttc_page_sizer u_sizer (
        .mode(mode),
        .large_page_enable(q.fcr[TTC_LPE_BIT]),
        .dir_pointer_ps(fill_dir_pointer_ps),
        .directory_ps(fill_directory_ps),
        .size(fill_size)
    );

    generate
        for (genvar gi = 0; gi < TTC_ENTRIES; gi++) begin : g_match
            ttc_entry_match u_match (
                .entry(q.ent[gi]),
                .vpn(lk_addr[TTC_LIN_W-1:TTC_OFS_W]),
                .cur_tag(q.tag),
                .hit(hit_vec[gi])
            );
        end
    endgenerate

    // lowest-index hit wins when page sizes overlap
    always_comb begin
        sel = '0;
        for (int i = TTC_ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                sel = q.ent[i];
            end
        end
        keep_lin = {4'h0, ttc_offset_mask(sel.size)};
        lin_pfn = {4'h0, lk_addr[TTC_LIN_W-1:TTC_OFS_W]};
    end

    // write legality, judged against the committed registers
    always_comb begin
        tef_old = q.fcr[TTC_TEF_BIT];
        tef_new = cr_wr_data[TTC_TEF_BIT];
        // tags may only come on in four-level paging with base tag zero
        bad_rise = !tef_old && tef_new
            && (mode != TTC_MODE_FOUR || q.base[TTC_TAG_W-1:0] != TTC_TAG_NONE);
        bad_pg_clear = tef_old && !cr_wr_data[TTC_PG_BIT];
        tef_clear = tef_old && !tef_new;
        fill_take = fill_valid && mode != TTC_MODE_OFF && fill_walk_ok;
    end

    // entry built from a walk result, under the tag current before this edge
    always_comb begin
        fresh.valid = 1'b1;
        fresh.tag = q.tag;
        fresh.global_page = fill_global;
        fresh.size = fill_size;
        // full page number kept; the size mask trims it at lookup
        fresh.vpn = fill_addr[TTC_LIN_W-1:TTC_OFS_W];
        fresh.frame = fill_frame;
        fresh.rw = fill_rw;
        fresh.us = fill_us;
        fresh.xd = fill_xd;
        fresh.dirty = fill_dirty;
        fresh.mtype = fill_mtype;
    end

    always_comb begin
        next_q = q;
        next_q.fault = 1'b0;
        next_q.lk_done = 1'b0;
        next_q.lk_hit = 1'b0;
        next_q.lk_walk = 1'b0;
        next_q.fill_done = 1'b0;
        next_q.fill_acc_req = 1'b0;
        flush = inv_all;

        // control register writes
        if (cr_wr_valid) begin
            unique case (cr_wr_sel)
                TTC_SEL_SYSC: begin
                    if (bad_pg_clear) begin
                        next_q.fault = 1'b1;
                    end else begin
                        next_q.sysc = cr_wr_data[31:0];
                    end
                end
                TTC_SEL_FCR: begin
                    if (bad_rise) begin
                        next_q.fault = 1'b1;
                    end else begin
                        next_q.fcr = cr_wr_data[31:0];
                        if (tef_clear) begin
                            flush = 1'b1;
                        end
                    end
                end
                TTC_SEL_BASE: begin
                    // entries under the old tag stay cached
                    next_q.base = cr_wr_data;
                end
                default: begin
                end
            endcase
        end

        // tag follows the registers as they stand after this edge
        if (next_q.fcr[TTC_TEF_BIT]) begin
            next_q.tag = next_q.base[TTC_TAG_W-1:0];
        end else begin
            next_q.tag = TTC_TAG_NONE;
        end

        // lookup, answered one cycle later
        if (lk_valid) begin
            next_q.lk_done = 1'b1;
            // paging off: identity map with full rights
            if (mode == TTC_MODE_OFF) begin
                next_q.lk_hit = 1'b1;
                next_q.lk_phys = {4'h0, lk_addr};
                next_q.lk_rw = 1'b1;
                next_q.lk_us = 1'b1;
                next_q.lk_xd = 1'b0;
                next_q.lk_dirty = 1'b0;
                next_q.lk_mtype = TTC_MT_UNPAGED;
            end else if (|hit_vec) begin
                next_q.lk_hit = 1'b1;
                next_q.lk_phys = {(sel.frame & ~keep_lin) | (lin_pfn & keep_lin),
                                  lk_addr[TTC_OFS_W-1:0]};
                next_q.lk_rw = sel.rw;
                next_q.lk_us = sel.us;
                next_q.lk_xd = sel.xd;
                next_q.lk_dirty = sel.dirty;
                next_q.lk_mtype = sel.mtype;
            end else begin
                next_q.lk_walk = 1'b1;
            end
        end

        // flush beats a fill so no stale-tag entry can survive
        if (flush) begin
            for (int i = 0; i < TTC_ENTRIES; i++) begin
                next_q.ent[i].valid = 1'b0;
            end
        end else if (fill_take) begin
            if (!fill_accessed_all) begin
                next_q.fill_acc_req = 1'b1;
            end else begin
                next_q.ent[q.victim] = fresh;
                // round robin over all entries, wrapping
                next_q.victim = q.victim + 3'h1;
                next_q.fill_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.victim <= TTC_VICTIM_RST;
            q.sysc <= TTC_SYSC_RST;
            q.fcr <= TTC_FCR_RST;
            q.base <= TTC_BASE_RST;
            q.tag <= TTC_TAG_NONE;
            q.lk_mtype <= TTC_MT_UNPAGED;
        end else begin
            q <= next_q;
        end
    end

    always_comb begin
        system_control_reg = q.sysc;
        fourth_control_reg = q.fcr;
        translation_base_reg = q.base;
        address_space_tag = q.tag;
        protection_fault = q.fault;
        lk_done = q.lk_done;
        lk_hit = q.lk_hit;
        lk_walk_req = q.lk_walk;
        lk_phys = q.lk_phys;
        lk_rw = q.lk_rw;
        lk_us = q.lk_us;
        lk_xd = q.lk_xd;
        lk_dirty = q.lk_dirty;
        lk_mtype = q.lk_mtype;
        fill_done = q.fill_done;
        fill_accessed_req = q.fill_acc_req;
    end

endmodule

// ### tb/ttc_cache_properties.sv
// port assertions for the translation cache
`timescale 1ns/100ps
module ttc_cache_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cr_wr_valid,
    input wire logic [1:0] cr_wr_sel,
    input wire logic [63:0] cr_wr_data,
    input wire logic long_mode_active,
    input wire logic inv_all,
    input wire logic lk_valid,
    input wire logic fill_valid,
    input wire logic fill_walk_ok,
    input wire logic fill_accessed_all,
    input wire logic [31:0] system_control_reg,
    input wire logic [31:0] fourth_control_reg,
    input wire logic [63:0] translation_base_reg,
    input wire logic [11:0] address_space_tag,
    input wire logic protection_fault,
    input wire logic lk_done,
    input wire logic lk_hit,
    input wire logic lk_walk_req,
    input wire logic fill_done,
    input wire logic fill_accessed_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_bad_rise;
        cr_wr_valid && cr_wr_sel == 2'h3 && cr_wr_data[17] && !fourth_control_reg[17]
            && (!long_mode_active || translation_base_reg[11:0] != 12'h000);
    endsequence
    sequence s_refused;
        protection_fault && $stable(fourth_control_reg);
    endsequence
    property p_tag_off; !fourth_control_reg[17] |-> address_space_tag == 12'h000; endproperty
    property p_tag_on;
        fourth_control_reg[17] |-> address_space_tag == translation_base_reg[11:0];
    endproperty
    property p_bad_rise; s_bad_rise |=> s_refused; endproperty
    property p_pg_clear;
        cr_wr_valid && cr_wr_sel == 2'h0 && !cr_wr_data[31] && fourth_control_reg[17]
            |=> protection_fault && $stable(system_control_reg);
    endproperty
    property p_fault_cause; protection_fault |-> $past(cr_wr_valid); endproperty
    property p_tef_mode; $rose(fourth_control_reg[17]) |-> $past(long_mode_active); endproperty
    property p_lookup; lk_valid |=> lk_done && (lk_hit != lk_walk_req); endproperty
    property p_fill;
        fill_valid && fill_walk_ok && system_control_reg[31] && !inv_all && !cr_wr_valid
            |=> fill_done == $past(fill_accessed_all) && fill_accessed_req != fill_done;
    endproperty
    a_tag_off: assert property (p_tag_off) else $error("tag not zero");
    a_tag_on: assert property (p_tag_on) else $error("tag not base low bits");
    a_bad_rise: assert property (p_bad_rise) else $error("bad enable accepted");
    a_pg_clear: assert property (p_pg_clear) else $error("paging off accepted");
    a_fault_cause: assert property (p_fault_cause) else $error("stray fault");
    a_tef_mode: assert property (p_tef_mode) else $error("enable outside long mode");
    a_lookup: assert property (p_lookup) else $error("lookup answer wrong");
    a_fill: assert property (p_fill) else $error("fill answer wrong");
endmodule
bind ttc_cache ttc_cache_properties u_props (.clk, .sys_rst, .cr_wr_valid, .cr_wr_sel,
    .cr_wr_data, .long_mode_active, .inv_all, .lk_valid, .fill_valid, .fill_walk_ok,
    .fill_accessed_all, .system_control_reg, .fourth_control_reg, .translation_base_reg,
    .address_space_tag, .protection_fault, .lk_done, .lk_hit, .lk_walk_req, .fill_done,
    .fill_accessed_req);

// ### tb/ttc_walker.sv
// page-walk partner: answers a walk request after a set delay
`timescale 1ns/100ps
module ttc_walker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic walk_req,
    input wire logic [47:0] addr,
    input wire logic [3:0] lat,
    input wire logic [1:0] ps,
    input wire logic glb,
    input wire logic acc,
    output logic fill_valid,
    output logic [47:0] fill_addr,
    output logic [39:0] fill_frame,
    output logic fill_dir_pointer_ps,
    output logic fill_directory_ps,
    output logic fill_rw,
    output logic fill_us,
    output logic fill_xd,
    output logic fill_dirty,
    output logic fill_global,
    output logic [2:0] fill_mtype,
    output logic fill_walk_ok,
    output logic fill_accessed_all
);
    logic busy;
    logic [3:0] cnt;
    logic [47:0] a;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            a <= 48'h0;
        end else if (walk_req && !busy) begin
            busy <= 1'b1;
            cnt <= lat;
            a <= addr;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else begin
            busy <= 1'b0;
        end
    end
    assign fill_valid = busy && cnt == 4'h0;
    // outside the pulse the address, frame and page-size lines carry inverted junk
    assign fill_addr = fill_valid ? a : ~a;
    assign fill_frame = fill_valid ? {a[47:12], 4'ha} : ~{a[47:12], 4'ha};
    assign {fill_dir_pointer_ps, fill_directory_ps} = fill_valid ? ps : ~ps;
    assign {fill_rw, fill_us, fill_xd, fill_dirty} = 4'hb;
    assign fill_mtype = 3'h6;
    assign fill_global = glb;
    assign fill_walk_ok = fill_valid;
    assign fill_accessed_all = acc;
endmodule

// ### tb/ttc_cache_tb_top.sv
// self-checking bench for the tagged translation cache
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module ttc_cache_tb_top;
    import ttc_pkg::*;
    logic clk = 0, sys_rst = 1, cr_wr_valid = 0, long_mode_active = 0, inv_all = 0;
    logic lk_valid = 0, w_glb = 0, w_acc = 1;
    logic [1:0] cr_wr_sel = 2'h0, w_ps = 2'h0;
    logic [3:0] w_lat = 4'h0;
    logic [63:0] cr_wr_data = 64'h0, translation_base_reg;
    logic [47:0] lk_addr = 48'h0, fill_addr;
    logic [39:0] fill_frame;
    logic [31:0] system_control_reg, fourth_control_reg;
    logic [11:0] address_space_tag;
    logic [51:0] lk_phys;
    logic [2:0] fill_mtype, lk_mtype;
    logic fill_valid, fill_dir_pointer_ps, fill_directory_ps, fill_rw, fill_us, fill_xd;
    logic fill_dirty, fill_global, fill_walk_ok, fill_accessed_all, protection_fault;
    logic lk_done, lk_hit, lk_walk_req, lk_rw, lk_us, lk_xd, lk_dirty, fill_done;
    logic fill_accessed_req;
    int num_errors = 0, checks_done = 0, cycles = 0;
    int ob [6] = '{12, 22, 21, 30, 21, 12};
    logic [1:0] pv [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h0};
    logic [47:0] ad [6] = '{48'h0000_4000_0000, 48'h0000_8000_0000, 48'h0000_c000_0000,
        48'h1000_4000_0000, 48'h2000_0000_0000, 48'h3000_0000_0000};
    ttc_cache dut (.clk, .sys_rst, .cr_wr_valid, .cr_wr_sel, .cr_wr_data, .long_mode_active,
        .inv_all, .lk_valid, .lk_addr, .fill_valid, .fill_addr, .fill_frame,
        .fill_dir_pointer_ps, .fill_directory_ps, .fill_rw, .fill_us, .fill_xd, .fill_dirty,
        .fill_global, .fill_mtype, .fill_walk_ok, .fill_accessed_all, .system_control_reg,
        .fourth_control_reg, .translation_base_reg, .address_space_tag, .protection_fault,
        .lk_done, .lk_hit, .lk_walk_req, .lk_phys, .lk_rw, .lk_us, .lk_xd, .lk_dirty,
        .lk_mtype, .fill_done, .fill_accessed_req);
    ttc_walker wlk (.clk, .sys_rst, .walk_req(lk_walk_req), .addr(lk_addr), .lat(w_lat),
        .ps(w_ps), .glb(w_glb), .acc(w_acc), .fill_valid, .fill_addr, .fill_frame,
        .fill_dir_pointer_ps, .fill_directory_ps, .fill_rw, .fill_us, .fill_xd, .fill_dirty,
        .fill_global, .fill_mtype, .fill_walk_ok, .fill_accessed_all);
    always #2 clk = ~clk;
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic cw(input logic [1:0] s, input logic [63:0] d, input logic f);
        @(negedge clk);
        cr_wr_valid = 1;
        cr_wr_sel = s;
        cr_wr_data = d;
        @(negedge clk);
        cr_wr_valid = 0;
        `CHK(protection_fault, f)
    endtask
    task automatic lk(input logic [47:0] a, input logic h);
        @(negedge clk);
        lk_valid = 1;
        lk_addr = a;
        @(negedge clk);
        lk_valid = 0;
        `CHK(lk_hit, h)
        `CHK(lk_done, 1'b1)
        `CHK(lk_walk_req, !h)
    endtask
    // miss, then wait for the walk result to be stored or refused
    task automatic lkw(input logic [47:0] a);
        int n = 0;
        lk(a, 0);
        while (fill_done !== 1'b1 && fill_accessed_req !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        `CHK(fill_done, w_acc)
        `CHK(fill_accessed_req, !w_acc)
    endtask
    task automatic hit(input logic [47:0] fa, input logic [47:0] la, input int b);
        logic [51:0] m;
        m = (52'h1 << b) - 52'h1;
        lk(la, 1);
        `CHK(lk_phys, ({fa[47:12], 4'ha, 12'h000} & ~m) | ({4'h0, la} & m))
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        sys_rst = 0;
        `CHK(address_space_tag, 12'h000)
        hit(48'h0, 48'h1234_5678_9abc, 48);
        `CHK({lk_rw, lk_us, lk_xd, lk_dirty, lk_mtype}, 7'h60)
        cw(TTC_SEL_SYSC, 64'h8000_0000, 0);
        for (int i = 0; i < 6; i++) begin
            cw(TTC_SEL_FCR, (i == 1) ? 64'h10 : (i == 2) ? 64'h20 : 64'h0, 0);
            long_mode_active = (i > 2);
            w_ps = pv[i];
            w_lat = 4'(i);
            lkw(ad[i]);
            hit(ad[i], ad[i] | ((48'h1 << ob[i]) - 48'h1), ob[i]);
            lkw(ad[i] + (48'h1 << ob[i]));
        end
        `CHK({lk_rw, lk_us, lk_xd, lk_dirty, lk_mtype}, 7'h5e)
        cw(TTC_SEL_FCR, 64'h2_0000, 0);
        cw(TTC_SEL_BASE, 64'h5, 0);
        `CHK(address_space_tag, 12'h005)
        `CHK(translation_base_reg, 64'h5)
        lkw(ad[5]);
        hit(ad[5], ad[5], 12);
        w_glb = 1;
        lkw(48'h4000_0000_0000);
        w_glb = 0;
        cw(TTC_SEL_BASE, 64'h0, 0);
        hit(48'h4000_0000_0000, 48'h4000_0000_0000, 12);
        hit(ad[5], ad[5], 12);
        cw(TTC_SEL_SYSC, 64'h0, 1);
        `CHK(system_control_reg[31], 1'b1)
        cw(TTC_SEL_FCR, 64'h0, 0);
        lkw(48'h4000_0000_0000);
        hit(48'h4000_0000_0000, 48'h4000_0000_0000, 12);
        @(negedge clk);
        inv_all = 1;
        @(negedge clk);
        inv_all = 0;
        w_acc = 0;
        lkw(48'h4000_0000_0000);
        w_acc = 1;
        lkw(48'h4000_0000_0000);
        cw(TTC_SEL_BASE, 64'h5, 0);
        `CHK(address_space_tag, 12'h000)
        cw(TTC_SEL_FCR, 64'h2_0000, 1);
        cw(TTC_SEL_BASE, 64'h0, 0);
        long_mode_active = 0;
        cw(TTC_SEL_FCR, 64'h2_0000, 1);
        `CHK(fourth_control_reg, 32'h0000_0000)
        cw(2'h1, 64'hffff_ffff_ffff_ffff, 0);
        `CHK({system_control_reg, fourth_control_reg}, 64'h8000_0000_0000_0000)
        `CHK(translation_base_reg, 64'h0)
        conclude();
    end
endmodule
